/* File: src/ceg_pkg.sv */
// Shared constants and carrier types for the calibration, excitation and pin register bank.
// Assumes a single 100 MHz clock domain and an in-device command decoder as register master.
package ceg_pkg;

    // Register addresses on the internal register port.
    localparam logic [3:0] ADDR_OFC_LOW   = 4'h4;
    localparam logic [3:0] ADDR_OFC_MID   = 4'h5;
    localparam logic [3:0] ADDR_OFC_HIGH  = 4'h6;
    localparam logic [3:0] ADDR_FSC_LOW   = 4'h7;
    localparam logic [3:0] ADDR_FSC_MID   = 4'h8;
    localparam logic [3:0] ADDR_FSC_HIGH  = 4'h9;
    localparam logic [3:0] ADDR_EXC_CTRL  = 4'ha;
    localparam logic [3:0] ADDR_EXC_ROUTE = 4'hb;
    localparam logic [3:0] ADDR_PIN_FUNC  = 4'hc;
    localparam logic [3:0] ADDR_PIN_DIR   = 4'hd;
    localparam logic [3:0] ADDR_PIN_DATA  = 4'he;

    // Field positions.
    localparam int CTRL_REV_LSB  = 4;
    localparam int CTRL_MODE_BIT = 3;
    localparam int CTRL_MAG_LSB  = 0;
    localparam int ROUTE_1_LSB   = 4;
    localparam int ROUTE_2_LSB   = 0;

    // Values after reset.
    localparam logic [23:0] OFC_RESET   = 24'h000000;
    localparam logic [2:0]  MAG_RESET   = 3'h0;
    localparam logic        MODE_RESET  = 1'b0;
    localparam logic [7:0]  ROUTE_RESET = 8'hff;
    localparam logic [7:0]  FUNC_RESET  = 8'h00;
    localparam logic [7:0]  DIR_RESET   = 8'h00;
    localparam logic [7:0]  DATA_RESET  = 8'h00;
    localparam logic [2:0]  GAIN_RESET  = 3'h0;
    localparam logic [7:0]  READ_ZERO   = 8'h00;

    // One register access from the command decoder.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } ceg_req_t;

    typedef enum logic [1:0] {ROUTE_AIN, ROUTE_PIN_ONE, ROUTE_PIN_TWO, ROUTE_OPEN} ceg_kind_t;

    typedef struct packed {
        ceg_kind_t  kind;
        logic [2:0] analog_input;
    } ceg_route_t;

    typedef struct packed {
        logic [2:0] magnitude;
        ceg_route_t first;
        ceg_route_t second;
    } ceg_exc_t;

    // Decodes a four-bit source routing code.
    function automatic ceg_route_t ceg_decode_route(input logic [3:0] code);
        ceg_route_t r;
        r.analog_input  = 3'h0;
        r.kind = ROUTE_OPEN;
        if (!code[3]) begin
            r.kind = ROUTE_AIN;
            r.analog_input  = code[2:0];
        end else if (!code[2]) begin
            r.kind = code[0] ? ROUTE_PIN_TWO : ROUTE_PIN_ONE;
        end
        return r;
    endfunction

endpackage

/* File: src/ceg_regs.sv */
// Calibration coefficient, excitation source and shared pin register bank.
// Assumes the command decoder and conversion datapath run on ref_clk; pin inputs are asynchronous.
//
// Summary of operation
// - Offset coefficient is 24 bits in three bytes, low byte at lowest address.
// - Reset clears all offset coefficient bytes.
// - Full-scale coefficient is 24 bits in three bytes, low byte lowest.
// - Full-scale reset value is the trimmed value for gain code 0.
// - Any gain change reloads full-scale with the trimmed value of the new gain.
// - Control register bits 7:4 are read-only revision bits.
// - Select bit 3 adds active-low ready to the serial output pin.
// - The dedicated ready pin always signals new data, active low.
// - Magnitude 000 turns sources off; other codes pick 50 to 1500 microamperes.
// - First route: inputs 0-7, pin one at 10x0, pin two 10x1, open 11xx.
// - Second route uses the same encoding as the first.
// - Both routes reset to disconnected, routing register all ones.
// - Pins 0,1 share reference pair 0; pins 2-7 share analog inputs 2-7.
// - Function bit 0 keeps analog input, 1 makes general pin; reset zero.
// - Direction bit 0 is output (reset), 1 is input.
// - A general output pin drives its written data bit.
// - Reading data returns the live level of input pins.
// - Reduced variant implements only bits 3:0; upper bits read zero.
// - Gain field is bits 6:4 of the system control register.
`timescale 1ns/1ps
`default_nettype none

module ceg_regs
    import ceg_pkg::*;
#(
    parameter int          PIN_COUNT = 8,
    // Arbitrary revision value.
    parameter logic [3:0]  REVISION  = 4'h5,
    // Trimmed full-scale value per gain code, code 0 in the low 24 bits.
    parameter logic [191:0] FS_TRIM  = {8{24'h400000}}
) (
    // Clock and reset.
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    // Register port from the command decoder.
    input  wire ceg_req_t   req,
    output logic [7:0]      rdata,
    output logic            rd_valid,
    // Gain field of the system control register.
    input  wire logic [2:0] amp_gain_field,
    // Calibration coefficients to the datapath.
    output logic [23:0]     offset_coeff_bits,
    output logic [23:0]     fullscale_coeff_bits,
    // Excitation source control.
    output ceg_exc_t        excitation,
    // Ready and serial output.
    input  wire logic       data_ready_n,
    input  wire logic       shift_active,
    input  wire logic       serial_data,
    output logic            conversion_ready_n,
    output logic            serial_out_ready_pin,
    // Shared general-purpose pins.
    input  wire logic [7:0] pin_in,
    output logic [7:0]      pin_out,
    output logic [7:0]      pin_oe,
    output logic [7:0]      pin_analog_en
);

    logic [2:0]  magnitude;
    logic        dual_output_select;
    logic [7:0]  route;
    logic [7:0]  pin_function_bits;
    logic [7:0]  pin_direction_bits;
    logic [7:0]  pin_value_bits;
    logic [2:0]  gain_seen;
    logic [7:0]  pin_meta;
    logic [7:0]  pin_sync;
    logic [7:0]  pin_mask;
    logic [7:0]  pin_read;
    logic [7:0]  next_rdata;
    ceg_exc_t    next_excitation;

    wire wr_ofc_lo  = req.wr && req.addr == ADDR_OFC_LOW;
    wire wr_ofc_mid = req.wr && req.addr == ADDR_OFC_MID;
    wire wr_ofc_hi  = req.wr && req.addr == ADDR_OFC_HIGH;
    wire wr_fsc_lo  = req.wr && req.addr == ADDR_FSC_LOW;
    wire wr_fsc_mid = req.wr && req.addr == ADDR_FSC_MID;
    wire wr_fsc_hi  = req.wr && req.addr == ADDR_FSC_HIGH;
    wire wr_ctrl    = req.wr && req.addr == ADDR_EXC_CTRL;
    wire wr_route   = req.wr && req.addr == ADDR_EXC_ROUTE;
    wire wr_func    = req.wr && req.addr == ADDR_PIN_FUNC;
    wire wr_dir     = req.wr && req.addr == ADDR_PIN_DIR;
    wire wr_data    = req.wr && req.addr == ADDR_PIN_DATA;

    wire        gain_changed = amp_gain_field != gain_seen;
    wire [23:0] trim_value   = FS_TRIM[24*amp_gain_field +: 24];

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            if (gi < PIN_COUNT) begin : g_on
                assign pin_mask[gi] = 1'b1;
                assign pin_read[gi] = pin_direction_bits[gi] ? pin_sync[gi] : pin_value_bits[gi];
            end else begin : g_off
                assign pin_mask[gi] = 1'b0;
                assign pin_read[gi] = 1'b0;
            end
        end
    endgenerate

    wire [7:0] ctrl_view = {REVISION, dual_output_select, magnitude};

    always_comb begin
        case (req.addr)
            ADDR_OFC_LOW:   next_rdata = offset_coeff_bits[7:0];
            ADDR_OFC_MID:   next_rdata = offset_coeff_bits[15:8];
            ADDR_OFC_HIGH:  next_rdata = offset_coeff_bits[23:16];
            ADDR_FSC_LOW:   next_rdata = fullscale_coeff_bits[7:0];
            ADDR_FSC_MID:   next_rdata = fullscale_coeff_bits[15:8];
            ADDR_FSC_HIGH:  next_rdata = fullscale_coeff_bits[23:16];
            ADDR_EXC_CTRL:  next_rdata = ctrl_view;
            ADDR_EXC_ROUTE: next_rdata = route;
            ADDR_PIN_FUNC:  next_rdata = pin_function_bits;
            ADDR_PIN_DIR:   next_rdata = pin_direction_bits;
            ADDR_PIN_DATA:  next_rdata = pin_read;
            default:        next_rdata = READ_ZERO;
        endcase
    end

    always_comb begin
        next_excitation.magnitude = magnitude;
        next_excitation.first     = ceg_decode_route(route[ROUTE_1_LSB +: 4]);
        next_excitation.second    = ceg_decode_route(route[ROUTE_2_LSB +: 4]);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata    <= READ_ZERO;
            rd_valid <= 1'b0;
        end else begin
            rdata    <= req.rd ? next_rdata : rdata;
            rd_valid <= req.rd;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            offset_coeff_bits <= OFC_RESET;
        end else begin
            if (wr_ofc_lo)  offset_coeff_bits[7:0]   <= req.wdata;
            if (wr_ofc_mid) offset_coeff_bits[15:8]  <= req.wdata;
            if (wr_ofc_hi)  offset_coeff_bits[23:16] <= req.wdata;
        end
    end

    // full-scale bytes; a gain reload beats a same-cycle write.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fullscale_coeff_bits <= FS_TRIM[23:0];
            gain_seen            <= GAIN_RESET;
        end else begin
            gain_seen <= amp_gain_field;
            if (gain_changed) begin
                fullscale_coeff_bits <= trim_value;
            end else begin
                if (wr_fsc_lo)  fullscale_coeff_bits[7:0]   <= req.wdata;
                if (wr_fsc_mid) fullscale_coeff_bits[15:8]  <= req.wdata;
                if (wr_fsc_hi)  fullscale_coeff_bits[23:16] <= req.wdata;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            magnitude          <= MAG_RESET;
            dual_output_select <= MODE_RESET;
            route              <= ROUTE_RESET;
        end else begin
            if (wr_ctrl) begin
                magnitude          <= req.wdata[CTRL_MAG_LSB +: 3];
                dual_output_select <= req.wdata[CTRL_MODE_BIT];
            end
            if (wr_route) route <= req.wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_function_bits  <= FUNC_RESET;
            pin_direction_bits <= DIR_RESET;
            pin_value_bits     <= DATA_RESET;
        end else begin
            if (wr_func) pin_function_bits  <= req.wdata & pin_mask;
            if (wr_dir)  pin_direction_bits <= req.wdata & pin_mask;
            if (wr_data) pin_value_bits     <= req.wdata & pin_mask;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta <= 8'h00;
            pin_sync <= 8'h00;
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            excitation           <= '{MAG_RESET, '{ROUTE_OPEN, 3'h0}, '{ROUTE_OPEN, 3'h0}};
            conversion_ready_n   <= 1'b1;
            serial_out_ready_pin <= 1'b1;
            pin_out              <= 8'h00;
            pin_oe               <= 8'h00;
            pin_analog_en        <= 8'h00;
        end else begin
            excitation           <= next_excitation;
            conversion_ready_n   <= data_ready_n;
            serial_out_ready_pin <= (dual_output_select && !shift_active) ? data_ready_n
                                                                           : serial_data;
            pin_out              <= pin_value_bits & pin_function_bits & ~pin_direction_bits;
            pin_oe               <= pin_function_bits & ~pin_direction_bits;
            pin_analog_en        <= ~pin_function_bits & pin_mask;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    AST_OFC_WRITE: assert property (
        wr_ofc_mid |=> offset_coeff_bits[15:8] == $past(req.wdata))
        else $error("offset middle byte not written");
    AST_OFC_LOW: assert property (
        wr_ofc_lo |=> offset_coeff_bits[7:0] == $past(req.wdata))
        else $error("offset low byte not written");
    AST_OFC_HIGH: assert property (
        wr_ofc_hi |=> offset_coeff_bits[23:16] == $past(req.wdata))
        else $error("offset high byte not written");
    AST_OFC_RESET: assert property (
        $rose(rst_b) |-> offset_coeff_bits == OFC_RESET)
        else $error("offset not cleared by reset");
    AST_FSC_WRITE: assert property (
        wr_fsc_mid && !gain_changed |=> fullscale_coeff_bits[15:8] == $past(req.wdata))
        else $error("full-scale middle byte not written");
    AST_FSC_HOLD: assert property (
        !gain_changed && !req.wr |=> $stable(fullscale_coeff_bits))
        else $error("full-scale changed without cause");
    AST_FSC_RESET: assert property (
        $rose(rst_b) |-> fullscale_coeff_bits == FS_TRIM[23:0])
        else $error("full-scale reset value wrong");
    AST_FSC_RELOAD: assert property (
        gain_changed |=> fullscale_coeff_bits == $past(trim_value))
        else $error("full-scale not reloaded on gain change");
    AST_REV_FIXED: assert property (
        req.rd && req.addr == ADDR_EXC_CTRL |=> rdata[7:4] == REVISION)
        else $error("revision bits altered");
    AST_CTRL_WRITE: assert property (
        wr_ctrl |=> ctrl_view[7:4] == REVISION && ctrl_view[3:0] == $past(req.wdata[3:0]))
        else $error("control write not applied to writable bits only");
    AST_CTRL_RESET: assert property (
        $rose(rst_b) |-> magnitude == MAG_RESET && dual_output_select == MODE_RESET)
        else $error("control reset value wrong");
    AST_DUAL_PIN: assert property (
        dual_output_select && !shift_active |=> serial_out_ready_pin == $past(data_ready_n))
        else $error("serial pin lacks ready indication");
    AST_SOUT_DATA: assert property (
        !dual_output_select || shift_active |=> serial_out_ready_pin == $past(serial_data))
        else $error("serial pin does not carry data");
    AST_READY_PIN: assert property (
        1'b1 |=> conversion_ready_n == $past(data_ready_n))
        else $error("ready pin does not follow data ready");
    AST_MAG: assert property (
        wr_ctrl |=> ##1 excitation.magnitude == $past(req.wdata[2:0], 2))
        else $error("magnitude not passed to the sources");
    AST_ROUTE_OPEN: assert property (
        route[7:6] == 2'b11 |=> excitation.first.kind == ROUTE_OPEN)
        else $error("first route not open");
    AST_ROUTE_AIN: assert property (
        !route[7] |=> excitation.first.kind == ROUTE_AIN
            && excitation.first.analog_input == $past(route[6:4]))
        else $error("first route not on analog input");
    AST_ROUTE_PIN: assert property (
        route[7:6] == 2'b10 |=> excitation.first.kind
            == ($past(route[4]) ? ROUTE_PIN_TWO : ROUTE_PIN_ONE))
        else $error("first route not on excitation pin");
    AST_ROUTE2_OPEN: assert property (
        route[3:2] == 2'b11 |=> excitation.second.kind == ROUTE_OPEN)
        else $error("second route not open");
    AST_ROUTE2_AIN: assert property (
        !route[3] |=> excitation.second.kind == ROUTE_AIN
            && excitation.second.analog_input == $past(route[2:0]))
        else $error("second route not on analog input");
    AST_ROUTE_RESET: assert property (
        $rose(rst_b) |-> route == ROUTE_RESET)
        else $error("routing reset value wrong");
    AST_ANALOG: assert property (
        pin_function_bits[0] |=> !pin_analog_en[0])
        else $error("general pin still analog");
    AST_ANALOG_KEEP: assert property (
        !pin_function_bits[0] |=> pin_analog_en[0])
        else $error("analog pin not kept analog");
    AST_FUNC_RESET: assert property (
        $rose(rst_b) |-> pin_function_bits == FUNC_RESET && pin_value_bits == DATA_RESET)
        else $error("pin function reset value wrong");
    AST_OE: assert property (
        1'b1 |=> pin_oe == $past(pin_function_bits & ~pin_direction_bits))
        else $error("pin enable wrong");
    AST_DIR_IN: assert property (
        pin_direction_bits[0] |=> !pin_oe[0])
        else $error("input pin driven");
    AST_DIR_RESET: assert property (
        $rose(rst_b) |-> pin_direction_bits == DIR_RESET)
        else $error("pin direction reset value wrong");
    AST_PIN_OUT: assert property (
        pin_function_bits[0] && !pin_direction_bits[0] |=> pin_out[0] == $past(pin_value_bits[0]))
        else $error("output pin does not show written data");
    AST_PIN_READ: assert property (
        req.rd && req.addr == ADDR_PIN_DATA && pin_direction_bits[0]
            |=> rdata[0] == $past(pin_sync[0]))
        else $error("input pin level not read back");
    AST_RD_VALID: assert property (
        req.rd |=> rd_valid ##1 (!rd_valid || $past(req.rd)))
        else $error("read answer missing");
    AST_UPPER_ZERO: assert property (
        (pin_function_bits & ~pin_mask) == 8'h00)
        else $error("unimplemented pin bit set");

endmodule

`default_nettype wire

/* File: testbench/ceg_pin_board.sv */
// Board model on the shared pins: a driven pin shows the block's value, else the outside level.
// Assumes one resolved level per pin, fed back to the block's pin inputs.
`timescale 1ns/1ps
`default_nettype none

module ceg_pin_board (
    // Block side.
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    // Outside world.
    input  wire logic [7:0] ext_level,
    output logic [7:0]      pin_in
);
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

`default_nettype wire

/* File: testbench/cal_excitation_gpio_regs_tb.sv */
// Self-checking bench for the register bank: reset values, coefficients, routing, gain and pins.
// Assumes the plain strobe register port, inputs driven 1 ns after each rising edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end

module cal_excitation_gpio_regs_tb;
    import ceg_pkg::*;
    localparam logic [191:0] TRIM = {24'h7f7f7f, 24'h6e6e6e, 24'h5d5d5d, 24'h4c4c4c,
                                     24'h3b3b3b, 24'h2a2a2a, 24'h191919, 24'h080808};
    logic       ref_clk = 1'b0;
    logic       rst_b = 1'b0;
    ceg_req_t   req = '0;
    logic [7:0] rdata;
    logic       rd_valid;
    logic [2:0] gain = 3'h0;
    logic [23:0] ofc;
    logic [23:0] fsc;
    ceg_exc_t   exc;
    logic       conversion_ready_n_n = 1'b1;
    logic       shift_active = 1'b0;
    logic       serial_data = 1'b0;
    logic       conv_n;
    logic       sout;
    logic [7:0] pin_in;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] pin_an;
    logic [7:0] ext = 8'h00;
    int         num_errors = 0;
    int         num_checks = 0;
    logic [7:0] rst_tab [16] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08,
                                 8'h08, 8'h08, 8'h50, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] rt_code [4] = '{8'h3c, 8'h89, 8'h7a, 8'hbf};
    logic [9:0] rt_exp [4];

    always #5 ref_clk = ~ref_clk;

    ceg_regs #(.FS_TRIM(TRIM)) i_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .req(req), .rdata(rdata), .rd_valid(rd_valid),
        .amp_gain_field(gain), .offset_coeff_bits(ofc), .fullscale_coeff_bits(fsc),
        .excitation(exc), .data_ready_n(conversion_ready_n_n), .shift_active(shift_active),
        .serial_data(serial_data), .conversion_ready_n(conv_n), .serial_out_ready_pin(sout),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_analog_en(pin_an));

    ceg_pin_board i_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext),
                           .pin_in(pin_in));

    task automatic close_out();
        $display("Checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk) #1;
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk) #1;
        req = '0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        int n;
        @(posedge ref_clk) #1;
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk) #1;
        req = '0;
        for (n = 0; n < 4 && rd_valid !== 1'b1; n++) begin
            @(posedge ref_clk) #1;
        end
        if (n == 4) begin
            num_errors++;
            close_out();
        end
        `CHK(rdata, e)
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    initial begin
        #1000000;
        num_errors++;
        close_out();
    end

    initial begin
        rt_exp = '{{ROUTE_AIN, 3'h3, ROUTE_OPEN, 3'h0}, {ROUTE_PIN_ONE, 3'h0, ROUTE_PIN_TWO, 3'h0},
                   {ROUTE_AIN, 3'h7, ROUTE_PIN_ONE, 3'h0}, {ROUTE_PIN_TWO, 3'h0, ROUTE_OPEN, 3'h0}};
        tick(5);
        rst_b = 1'b1;
        tick(1);
        `CHK(pin_an, 8'hff)
        for (int i = 0; i < 16; i++) rd(i[3:0], rst_tab[i]);
        wr(ADDR_OFC_LOW, 8'hab);
        wr(ADDR_OFC_MID, 8'hcd);
        wr(ADDR_OFC_HIGH, 8'hef);
        `CHK(ofc, 24'hefcdab)
        rd(ADDR_OFC_HIGH, 8'hef);
        wr(ADDR_FSC_LOW, 8'h12);
        wr(ADDR_FSC_MID, 8'h34);
        wr(ADDR_FSC_HIGH, 8'h56);
        `CHK(fsc, 24'h563412)
        rd(ADDR_FSC_MID, 8'h34);
        for (int g = 1; g < 9; g++) begin
            gain = g[2:0];
            tick(1);
            `CHK(fsc, TRIM[24 * (g % 8) +: 24])
        end
        wr(4'h0, 8'h77);
        rd(4'h0, 8'h00);
        wr(ADDR_EXC_CTRL, 8'hff);
        rd(ADDR_EXC_CTRL, 8'h5f);
        for (int m = 0; m < 8; m++) begin
            wr(ADDR_EXC_CTRL, m[7:0]);
            tick(1);
            `CHK(exc.magnitude, m[2:0])
        end
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_EXC_ROUTE, rt_code[i]);
            tick(1);
            `CHK({exc.first, exc.second}, rt_exp[i])
        end
        serial_data = 1'b1;
        conversion_ready_n_n = 1'b0;
        tick(1);
        `CHK(conv_n, 1'b0)
        `CHK(sout, 1'b1)
        wr(ADDR_EXC_CTRL, 8'h08);
        tick(1);
        `CHK(sout, 1'b0)
        `CHK(conv_n, 1'b0)
        shift_active = 1'b1;
        conversion_ready_n_n = 1'b1;
        serial_data = 1'b0;
        tick(1);
        `CHK(sout, 1'b0)
        `CHK(conv_n, 1'b1)
        wr(ADDR_PIN_DATA, 8'ha5);
        `CHK(pin_oe, 8'h00)
        wr(ADDR_PIN_FUNC, 8'hff);
        wr(ADDR_PIN_DIR, 8'h0f);
        tick(1);
        `CHK(pin_oe, 8'hf0)
        `CHK(pin_out, 8'ha0)
        `CHK(pin_an, 8'h00)
        ext = 8'h96;
        tick(3);
        rd(ADDR_PIN_DATA, 8'ha6);
        wr(ADDR_PIN_FUNC, 8'h0f);
        tick(1);
        `CHK(pin_an, 8'hf0)
        `CHK(pin_oe, 8'h00)
        close_out();
    end
endmodule

`default_nettype wire
